/* File: common/intc_defs.svh */
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL_MAIN      8'h00
`define ADDR_EDGE_PRIO      8'h04
`define ADDR_EXT_CTRL       8'h08
`define ADDR_PERIPH_FLAGS   8'h0C
`define ADDR_PRIO_MODE      8'h10
`define ADDR_PERIPH_ENABLE  8'h14
`define ADDR_PERIPH_PRIO    8'h18
`define ADDR_IRQ_STATUS     8'h1C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL_MAIN       8'h00
`define RST_EDGE_PRIO       8'hF5
`define RST_EXT_CTRL        8'hC0
`define RST_PERIPH_FLAGS    8'h00
`define RST_PERIPH_ENABLE   8'h00
`define RST_PERIPH_PRIO     8'hFF

// ----------------------------------------
// Field positions and read masks
// ----------------------------------------
`define MAIN_GIE     7
`define MAIN_PEIE    6
`define MAIN_T0IE    5
`define MAIN_X0IE    4
`define MAIN_PCIE    3
`define MAIN_T0IF    2
`define MAIN_X0IF    1
`define MAIN_PCIF    0
`define EP_PUDIS     7
`define EP_EDGE0     6
`define EP_EDGE1     5
`define EP_EDGE2     4
`define EP_T0IP      2
`define EP_PCIP      0
`define EX_X2IP      7
`define EX_X1IP      6
`define EX_X2IE      4
`define EX_X1IE      3
`define EX_X2IF      1
`define EX_X1IF      0
`define PF_PAR       7
`define PF_RXF       5
`define PF_TXE       4
`define PF_CCP       2
`define PRIO_MODE_BIT 7
`define EP_RMASK     8'hF5
`define EX_RMASK     8'hDB

// ----------------------------------------
// Vectors
// ----------------------------------------
`define VEC_HIGH     16'h0008
`define VEC_LOW      16'h0018

`endif

/* File: common/intc_pkg.sv */
package intc_pkg;
  typedef enum logic [1:0] {
    CCP_CAPTURE = 2'b00,
    CCP_COMPARE = 2'b01,
    CCP_PWM     = 2'b10,
    CCP_OFF     = 2'b11
  } ccp_mode_t;

  typedef struct packed {
    logic       timer_zero_overflow;
    logic [2:0] ext_pin;
    logic       conversion_done;
    logic       sync_serial_done;
    logic       parallel_access;
    logic       ccp_capture;
    logic       ccp_compare;
    logic       timer_two_match;
    logic       timer_one_overflow;
    logic       rx_buffer_full;
    logic       tx_buffer_empty;
  } event_in_t;

  typedef struct packed {
    logic        req;
    logic        high;
    logic [15:0] vector;
  } irq_out_t;

  typedef struct packed {
    logic        sel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } ahb_addr_t;
endpackage

/* File: logic/interrupt_control_flag_registers.sv */
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "intc_defs.svh"
module interrupt_control_flag_registers #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire intc_pkg::event_in_t events,
  input  wire intc_pkg::ccp_mode_t ccp_mode,
  input  wire logic [3:0]          port_b_pins,
  input  wire logic                port_b_read,
  input  wire logic                serial_receive_buffer_read,
  input  wire logic                serial_transmit_buffer_write,
  input  wire logic                irq_accept,
  input  wire logic                return_from_interrupt_instr,
  output intc_pkg::irq_out_t       irq,
  output logic                     pullup_disable_all
);
  import intc_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  ahb_addr_t aph_ff;
  logic [7:0] ctrl_main_ff;
  logic [7:0] edge_prio_ff;
  logic [7:0] ext_ctrl_ff;
  logic [7:0] periph_flags_ff;
  logic [7:0] periph_enable_ff;
  logic [7:0] periph_prio_ff;
  logic       priority_mode_enable_ff;
  logic [3:0] port_latch_ff;
  logic [2:0] ext_prev_ff;
  logic       irq_active_high_ff;
  logic       irq_active_low_ff;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wdat;
  logic [7:0] rd_byte;
  logic [7:0] ext_edge;
  logic       mismatch;
  logic [7:0] periph_ev;
  logic [7:0] periph_req;
  logic       hi_pend;
  logic       lo_pend;
  logic       compat_pend;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = aph_ff.sel & aph_ff.hwrite;
  assign rd_en     = aph_ff.sel & ~aph_ff.hwrite;
  assign wdat      = hwdata[7:0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aph_ff <= '0;
    end else if (hready) begin
      aph_ff.sel    <= hsel & htrans[1];
      aph_ff.haddr  <= haddr;
      aph_ff.htrans <= htrans;
      aph_ff.hwrite <= hwrite;
      aph_ff.hsize  <= hsize;
    end
  end

  // Registers answer with zero wait states; unmapped words read zero and ignore writes.
  always_comb begin
    rd_byte = 8'h00;
    unique case (haddr[7:0])
      `ADDR_CTRL_MAIN:     rd_byte = ctrl_main_ff;
      `ADDR_EDGE_PRIO:     rd_byte = edge_prio_ff & `EP_RMASK;
      `ADDR_EXT_CTRL:      rd_byte = ext_ctrl_ff & `EX_RMASK;
      `ADDR_PERIPH_FLAGS:  rd_byte = periph_flags_ff;
      `ADDR_PRIO_MODE:     rd_byte = {priority_mode_enable_ff, 7'h00};
      `ADDR_PERIPH_ENABLE: rd_byte = periph_enable_ff;
      `ADDR_PERIPH_PRIO:   rd_byte = periph_prio_ff;
      `ADDR_IRQ_STATUS:    rd_byte = {4'h0, irq_active_low_ff, irq_active_high_ff, irq.high, irq.req};
      default:             rd_byte = 8'h00;
    endcase
  end

  // Read data is captured at the address phase so that it stands for the whole data phase.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel & htrans[1] & ~hwrite & hready) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ext
      // Edge select: one picks rising, zero picks falling.
      assign ext_edge[gi] = edge_prio_ff[`EP_EDGE0 - gi] ? events.ext_pin[gi] & ~ext_prev_ff[gi]
                                                           : ~events.ext_pin[gi] & ext_prev_ff[gi];
    end
  endgenerate
  assign ext_edge[7:3] = 5'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_prev_ff <= 3'h0;
    end else begin
      ext_prev_ff <= events.ext_pin;
    end
  end

  // The latch only refreshes on a port read, so a change keeps re-setting the flag.
  assign mismatch = port_b_pins != port_latch_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_latch_ff <= 4'h0;
    end else if (port_b_read) begin
      port_latch_ff <= port_b_pins;
    end
  end

  assign pullup_disable_all = edge_prio_ff[`EP_PUDIS];

  // ----------------------------------------
  // Main control register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_main_ff <= `RST_CTRL_MAIN;
    end else begin
      if (wr_en && aph_ff.haddr[7:0] == `ADDR_CTRL_MAIN) begin
        ctrl_main_ff <= wdat;
      end
      // Hardware sets win over a software clear in the same cycle.
      if (events.timer_zero_overflow) begin
        ctrl_main_ff[`MAIN_T0IF] <= 1'b1;
      end
      if (ext_edge[0]) begin
        ctrl_main_ff[`MAIN_X0IF] <= 1'b1;
      end
      if (mismatch) begin
        ctrl_main_ff[`MAIN_PCIF] <= 1'b1;
      end
      if (irq_accept) begin
        if (!priority_mode_enable_ff || hi_pend) begin
          ctrl_main_ff[`MAIN_GIE] <= 1'b0;
        end else begin
          ctrl_main_ff[`MAIN_PEIE] <= 1'b0;
        end
      end else if (return_from_interrupt_instr) begin
        if (!priority_mode_enable_ff || irq_active_high_ff) begin
          ctrl_main_ff[`MAIN_GIE] <= 1'b1;
        end else begin
          ctrl_main_ff[`MAIN_PEIE] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_active_high_ff <= 1'b0;
      irq_active_low_ff  <= 1'b0;
    end else if (irq_accept) begin
      irq_active_high_ff <= !priority_mode_enable_ff || hi_pend;
      irq_active_low_ff  <= priority_mode_enable_ff && !hi_pend;
    end else if (return_from_interrupt_instr) begin
      if (irq_active_high_ff) begin
        irq_active_high_ff <= 1'b0;
      end else begin
        irq_active_low_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Edge, priority and external registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      edge_prio_ff <= `RST_EDGE_PRIO;
    end else if (wr_en && aph_ff.haddr[7:0] == `ADDR_EDGE_PRIO) begin
      edge_prio_ff <= wdat & `EP_RMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_ctrl_ff <= `RST_EXT_CTRL;
    end else begin
      if (wr_en && aph_ff.haddr[7:0] == `ADDR_EXT_CTRL) begin
        ext_ctrl_ff <= wdat & `EX_RMASK;
      end
      if (ext_edge[2]) begin
        ext_ctrl_ff[`EX_X2IF] <= 1'b1;
      end
      if (ext_edge[1]) begin
        ext_ctrl_ff[`EX_X1IF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      priority_mode_enable_ff <= 1'b0;
    end else if (wr_en && aph_ff.haddr[7:0] == `ADDR_PRIO_MODE) begin
      priority_mode_enable_ff <= wdat[`PRIO_MODE_BIT];
    end
  end

  // ----------------------------------------
  // Peripheral flags
  // ----------------------------------------
  assign periph_ev = {events.parallel_access & ~SMALL_PACKAGE, events.conversion_done, 2'b00,
                      events.sync_serial_done,
                      (ccp_mode == CCP_CAPTURE & events.ccp_capture) |
                      (ccp_mode == CCP_COMPARE & events.ccp_compare),
                      events.timer_two_match, events.timer_one_overflow};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      periph_flags_ff <= `RST_PERIPH_FLAGS;
    end else begin
      if (wr_en && aph_ff.haddr[7:0] == `ADDR_PERIPH_FLAGS) begin
        periph_flags_ff[7:6] <= wdat[7:6];
        periph_flags_ff[3:0] <= wdat[3:0];
      end
      periph_flags_ff <= periph_flags_ff | periph_ev;
      if (wr_en && aph_ff.haddr[7:0] == `ADDR_PERIPH_FLAGS) begin
        periph_flags_ff[7:6] <= wdat[7:6] | periph_ev[7:6];
        periph_flags_ff[3:0] <= wdat[3:0] | periph_ev[3:0];
      end
      if (SMALL_PACKAGE) begin
        periph_flags_ff[`PF_PAR] <= 1'b0;
      end
      // Buffer status follows the serial unit, with the access clearing it at once.
      periph_flags_ff[`PF_RXF] <= events.rx_buffer_full & ~serial_receive_buffer_read;
      periph_flags_ff[`PF_TXE] <= events.tx_buffer_empty & ~serial_transmit_buffer_write;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      periph_enable_ff <= `RST_PERIPH_ENABLE;
      periph_prio_ff   <= `RST_PERIPH_PRIO;
    end else if (wr_en && aph_ff.haddr[7:0] == `ADDR_PERIPH_ENABLE) begin
      periph_enable_ff <= wdat;
    end else if (wr_en && aph_ff.haddr[7:0] == `ADDR_PERIPH_PRIO) begin
      periph_prio_ff <= wdat;
    end
  end

  // ----------------------------------------
  // Request generation
  // ----------------------------------------
  assign periph_req = periph_flags_ff & periph_enable_ff;

  // Core sources are not gated by the peripheral enable in compatibility mode.
  assign compat_pend = ctrl_main_ff[`MAIN_GIE] & (
      (ctrl_main_ff[`MAIN_T0IF] & ctrl_main_ff[`MAIN_T0IE]) |
      (ctrl_main_ff[`MAIN_X0IF] & ctrl_main_ff[`MAIN_X0IE]) |
      (ctrl_main_ff[`MAIN_PCIF] & ctrl_main_ff[`MAIN_PCIE]) |
      (ext_ctrl_ff[`EX_X1IF] & ext_ctrl_ff[`EX_X1IE]) |
      (ext_ctrl_ff[`EX_X2IF] & ext_ctrl_ff[`EX_X2IE]) |
      (ctrl_main_ff[`MAIN_PEIE] & |periph_req));

  // External pin zero has no priority bit and is always high priority.
  assign hi_pend = ctrl_main_ff[`MAIN_GIE] & (
      (ctrl_main_ff[`MAIN_T0IF] & ctrl_main_ff[`MAIN_T0IE] & edge_prio_ff[`EP_T0IP]) |
      (ctrl_main_ff[`MAIN_X0IF] & ctrl_main_ff[`MAIN_X0IE]) |
      (ctrl_main_ff[`MAIN_PCIF] & ctrl_main_ff[`MAIN_PCIE] & edge_prio_ff[`EP_PCIP]) |
      (ext_ctrl_ff[`EX_X1IF] & ext_ctrl_ff[`EX_X1IE] & ext_ctrl_ff[`EX_X1IP]) |
      (ext_ctrl_ff[`EX_X2IF] & ext_ctrl_ff[`EX_X2IE] & ext_ctrl_ff[`EX_X2IP]) |
      |(periph_req & periph_prio_ff));

  assign lo_pend = ctrl_main_ff[`MAIN_GIE] & ctrl_main_ff[`MAIN_PEIE] & ~irq_active_high_ff & (
      (ctrl_main_ff[`MAIN_T0IF] & ctrl_main_ff[`MAIN_T0IE] & ~edge_prio_ff[`EP_T0IP]) |
      (ctrl_main_ff[`MAIN_PCIF] & ctrl_main_ff[`MAIN_PCIE] & ~edge_prio_ff[`EP_PCIP]) |
      (ext_ctrl_ff[`EX_X1IF] & ext_ctrl_ff[`EX_X1IE] & ~ext_ctrl_ff[`EX_X1IP]) |
      (ext_ctrl_ff[`EX_X2IF] & ext_ctrl_ff[`EX_X2IE] & ~ext_ctrl_ff[`EX_X2IP]) |
      |(periph_req & ~periph_prio_ff));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= '0;
    end else if (!priority_mode_enable_ff) begin
      irq.req    <= compat_pend & ~irq_active_high_ff;
      irq.high   <= compat_pend;
      irq.vector <= `VEC_HIGH;
    end else begin
      irq.req    <= hi_pend | lo_pend;
      irq.high   <= hi_pend;
      irq.vector <= hi_pend ? `VEC_HIGH : `VEC_LOW;
    end
  end

endmodule

/* File: verification/interrupt_control_flag_registers_chk.sv */
`timescale 1ns/100ps
`include "intc_defs.svh"
module intc_flag_chk (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               irq_accept,
  input wire logic               return_from_interrupt_instr,
  input wire intc_pkg::irq_out_t irq,
  input wire logic               pullup_disable_all
);
  import intc_pkg::*;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Bus and core events
  // ----------------------------------------
  sequence rd_at(logic [7:0] a);
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
  endsequence
  sequence wr_edge;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == `ADDR_EDGE_PRIO;
  endsequence
  // Only a high-level accept silences everything; a low one leaves high sources live.
  sequence hi_accept;
    irq_accept && irq.req && irq.high && !return_from_interrupt_instr;
  endsequence
  sequence quiet;
    !return_from_interrupt_instr && !(hsel && htrans[1] && hwrite);
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  a_no_wait: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_byte_lane: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_vec_legal: assert property (irq.req |-> irq.vector inside {16'h0008, 16'h0018})
    else $error("request carries an unknown vector");
  a_high_vec: assert property (irq.req && irq.high |-> irq.vector == 16'h0008)
    else $error("high request not at the high vector");
  a_edge_holes: assert property (rd_at(`ADDR_EDGE_PRIO) |=> hrdata[3:0] ==? 4'b0?0?)
    else $error("edge register hole read as one");
  a_ext_holes: assert property (rd_at(`ADDR_EXT_CTRL) |=> !hrdata[5] && !hrdata[2])
    else $error("external register hole read as one");
  a_pullup_write: assert property (wr_edge ##1 1'b1 |=> pullup_disable_all == $past(hwdata[7]))
    else $error("pull-up disable does not follow its bit");
  a_accept_drop: assert property (hi_accept ##1 quiet |=> !irq.req)
    else $error("request still up after high accept");
endmodule
bind interrupt_control_flag_registers intc_flag_chk u_chk (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq_accept, .return_from_interrupt_instr, .irq,
  .pullup_disable_all);

/* File: verification/event_source_model.sv */
`timescale 1ns/100ps
module event_source_model (
  input wire logic          core_clk,
  output intc_pkg::event_in_t events
);
  import intc_pkg::*;
  initial events = '0;
  // A pulse lasts exactly one cycle; a longer one would set a flag twice.
  task automatic pulse(input event_in_t m, input int lag);
    repeat (lag) @(posedge core_clk);
    events <= events | m;
    @(posedge core_clk);
    events <= events & ~m;
  endtask
  task automatic level(input event_in_t v);
    events <= v;
    @(posedge core_clk);
  endtask
endmodule

/* File: verification/test_interrupt_control_flag_registers.sv */
`timescale 1ns/100ps
`include "intc_defs.svh"
module test_interrupt_control_flag_registers;
  import intc_pkg::*;
  logic        core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        port_b_read, irq_accept, return_from_interrupt_instr, pullup_disable_all;
  logic        serial_receive_buffer_read, serial_transmit_buffer_write;
  logic        rd_ph = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] exp_q[$];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  port_b_pins;
  logic [7:0]  r;
  logic [7:0]  ra [6] = '{`ADDR_CTRL_MAIN, `ADDR_EDGE_PRIO, `ADDR_EXT_CTRL, `ADDR_PERIPH_FLAGS, `ADDR_PRIO_MODE, 8'h40};
  logic [7:0]  re [6] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00};
  ccp_mode_t   ccp_mode;
  event_in_t   events;
  irq_out_t    irq;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  interrupt_control_flag_registers dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .events, .ccp_mode, .port_b_pins, .port_b_read,
    .serial_receive_buffer_read, .serial_transmit_buffer_write, .irq_accept, .return_from_interrupt_instr,
    .irq, .pullup_disable_all);
  event_source_model src (.core_clk, .events);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic irqchk(input logic q, input logic [15:0] v);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, irq.req, irq.req ? irq.vector : 16'h0}, {15'h0, q, v});
    @(posedge core_clk);
  endtask
  task automatic core(input logic acc);
    if (acc) irq_accept <= 1'b1;
    else return_from_interrupt_instr <= 1'b1;
    @(posedge core_clk);
    irq_accept <= 1'b0;
    return_from_interrupt_instr <= 1'b0;
  endtask
  // Flags are cleared before the pin moves so that only this edge can set them.
  task automatic pin_step(input logic [2:0] p, input logic [7:0] em, input logic [7:0] ex);
    wr(`ADDR_CTRL_MAIN, 8'h00);
    wr(`ADDR_EXT_CTRL, 8'h00);
    src.level('{ext_pin: p, default: '0});
    repeat (3) @(posedge core_clk);
    rd(`ADDR_CTRL_MAIN, em);
    rd(`ADDR_EXT_CTRL, ex);
  endtask
  always @(posedge core_clk) rd_ph <= hsel && htrans[1] && !hwrite && hready && rst_n;
  always @(negedge core_clk) if (rd_ph) check(hrdata, exp_q.pop_front());
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hsize, port_b_pins, port_b_read} = '0;
    {serial_receive_buffer_read, serial_transmit_buffer_write, irq_accept, return_from_interrupt_instr} = '0;
    ccp_mode = CCP_CAPTURE;
    rst_n = 1'b0;
    void'($urandom(98));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], re[i]);
    check({31'h0, pullup_disable_all}, 32'h1);
    repeat (6) begin
      r = 8'($urandom);
      wr(`ADDR_EDGE_PRIO, r);
      rd(`ADDR_EDGE_PRIO, r & 8'hF5);
      check({31'h0, pullup_disable_all}, {31'h0, r[7]});
      wr(`ADDR_EXT_CTRL, r);
      rd(`ADDR_EXT_CTRL, r & 8'hDB);
    end
    for (int e = 0; e < 2; e++) begin
      wr(`ADDR_EDGE_PRIO, e ? 8'h70 : 8'h00);
      pin_step(e ? 3'b000 : 3'b111, 8'h00, 8'h00);
      pin_step(e ? 3'b111 : 3'b000, 8'h02, 8'h03);
      pin_step(e ? 3'b000 : 3'b111, 8'h00, 8'h00);
    end
    src.pulse('{parallel_access: 1'b1, conversion_done: 1'b1, sync_serial_done: 1'b1, ccp_capture: 1'b1,
      timer_two_match: 1'b1, timer_one_overflow: 1'b1, default: '0}, $urandom_range(2));
    repeat (2) @(posedge core_clk);
    rd(`ADDR_PERIPH_FLAGS, 8'hCF);
    wr(`ADDR_PERIPH_FLAGS, 8'h00);
    rd(`ADDR_PERIPH_FLAGS, 8'h00);
    for (int m = 0; m < 8; m++) begin
      ccp_mode <= ccp_mode_t'(m[2:1]);
      src.pulse('{ccp_capture: !m[0], ccp_compare: m[0], default: '0}, 1);
      repeat (2) @(posedge core_clk);
      rd(`ADDR_PERIPH_FLAGS, (m[2:1] == {1'b0, m[0]}) ? 8'h04 : 8'h00);
      wr(`ADDR_PERIPH_FLAGS, 8'h00);
    end
    src.level('{rx_buffer_full: 1'b1, default: '0});
    wr(`ADDR_PERIPH_FLAGS, 8'h00);
    rd(`ADDR_PERIPH_FLAGS, 8'h20);
    src.level('{rx_buffer_full: 1'b1, tx_buffer_empty: 1'b1, default: '0});
    repeat (2) @(posedge core_clk);
    rd(`ADDR_PERIPH_FLAGS, 8'h30);
    serial_receive_buffer_read <= 1'b1;
    serial_transmit_buffer_write <= 1'b1;
    @(posedge core_clk);
    serial_receive_buffer_read <= 1'b0;
    serial_transmit_buffer_write <= 1'b0;
    rd(`ADDR_PERIPH_FLAGS, 8'h00);
    src.level('0);
    repeat (2) @(posedge core_clk);
    rd(`ADDR_PERIPH_FLAGS, 8'h00);
    src.pulse('{timer_zero_overflow: 1'b1, default: '0}, $urandom_range(2));
    repeat (2) @(posedge core_clk);
    rd(`ADDR_CTRL_MAIN, 8'h04);
    irqchk(1'b0, 16'h0);
    wr(`ADDR_CTRL_MAIN, 8'h00);
    wr(`ADDR_CTRL_MAIN, 8'hA0);
    src.pulse('{timer_zero_overflow: 1'b1, default: '0}, 0);
    irqchk(1'b1, 16'h0008);
    core(1'b1);
    irqchk(1'b0, 16'h0);
    rd(`ADDR_CTRL_MAIN, 8'h24);
    core(1'b0);
    irqchk(1'b1, 16'h0008);
    rd(`ADDR_CTRL_MAIN, 8'hA4);
    wr(`ADDR_PRIO_MODE, 8'h80);
    wr(`ADDR_EDGE_PRIO, 8'h00);
    irqchk(1'b0, 16'h0);
    wr(`ADDR_CTRL_MAIN, 8'hE4);
    irqchk(1'b1, 16'h0018);
    core(1'b1);
    irqchk(1'b0, 16'h0);
    wr(`ADDR_EDGE_PRIO, 8'h04);
    irqchk(1'b1, 16'h0008);
    core(1'b1);
    irqchk(1'b0, 16'h0);
    rd(`ADDR_CTRL_MAIN, 8'h24);
    core(1'b0);
    rd(`ADDR_CTRL_MAIN, 8'hA4);
    wr(`ADDR_PRIO_MODE, 8'h00);
    wr(`ADDR_PERIPH_ENABLE, 8'h40);
    src.pulse('{conversion_done: 1'b1, default: '0}, 0);
    wr(`ADDR_CTRL_MAIN, 8'h80);
    irqchk(1'b0, 16'h0);
    wr(`ADDR_CTRL_MAIN, 8'hC0);
    irqchk(1'b1, 16'h0008);
    wr(`ADDR_CTRL_MAIN, 8'h00);
    port_b_pins <= 4'hA;
    repeat (3) @(posedge core_clk);
    rd(`ADDR_CTRL_MAIN, 8'h01);
    wr(`ADDR_CTRL_MAIN, 8'h00);
    rd(`ADDR_CTRL_MAIN, 8'h01);
    port_b_read <= 1'b1;
    @(posedge core_clk);
    port_b_read <= 1'b0;
    wr(`ADDR_CTRL_MAIN, 8'h00);
    rd(`ADDR_CTRL_MAIN, 8'h00);
    repeat (3) @(posedge core_clk);
    tally_and_finish();
  end
endmodule
